// File: tct_pkg.sv
package tct_pkg;

  // Clock and timing.
  localparam int CLK_HZ      = 20_000_000;
  localparam int T_CONV9_MS  = 150;
  localparam int CONV9_CYC   = T_CONV9_MS * (CLK_HZ / 1_000);
  localparam int T_ALONE_US  = 1000;
  localparam int ALONE_CYC   = T_ALONE_US * (CLK_HZ / 1_000_000);

  // Register pointer values.
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_TRIP = 2'h3;
  localparam logic [1:0] PTR_RESET = PTR_TEMP;

  // Configuration byte fields.
  localparam int CFG_SD      = 0;
  localparam int CFG_TM      = 1;
  localparam int CFG_POL     = 2;
  localparam int CFG_FT_LSB  = 3;
  localparam int CFG_RES_LSB = 5;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] CFG_WMASK  = 8'h7F;

  // Reset values of the data registers, and the 70 C standalone release setpoint for low data.
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] TRIP_RESET = 16'h5000;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] ALONE_HYST_SDA_LO = 16'h4600;

  // Serial bus framing.
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  // Slave address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_ACK   = 6'b000100,
    ST_WRITE = 6'b001000,
    ST_READ  = 6'b010000,
    ST_RACK  = 6'b100000
  } tct_bus_state_t;

endpackage : tct_pkg

// File: tct_core.sv
// Operation
// - After reset conversions start by themselves at 9-bit resolution.
// - Temperature holds last finished result; reads never disturb conversion.
// - Conversions repeat back to back while shutdown is off.
// - Shutdown finishes and stores current conversion, then stands by.
// - Resolution selectable 9 to 12 bits, steps 0.5 to 0.0625 C.
// - Each extra resolution bit doubles conversion time.
// - Results are two's complement Celsius, e.g. 0080h and FF80h.
// - Top bit is sign, lower bits weigh 2^6 down to 2^-4.
// - Unused low result bits read zero below 12-bit resolution.
// - Pointer value 00h selects temperature and is the reset value.
// - Serial register transfers go most significant bit first.
// - Every finished result is compared with both setpoints.
// - Setpoints reset to 80 C trip and 75 C release.
// - Comparator and interrupt alarm modes are supported.
// - Alarm needs a programmable count of consecutive out-of-limit results.
// - Reset gives comparator mode with a single fault enough.
// - With clock pin held low, data pin level selects hysteresis.
// - Comparator alarm stays until first result below release setpoint.
// - Interrupt alarm clears on shutdown or any read; next trips low.
// - Fault field codes 00..11 need 1, 2, 4, 6 conversions.
// - Alarm polarity is configurable and resets to active low.
`timescale 1ns/1ps

module tct_core
  import tct_pkg::*;
#(
  parameter int         CONV9_CYCLES = CONV9_CYC,
  parameter int         ALONE_CYCLES = ALONE_CYC,
  parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEFAULT
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Sensor converter sample, 1/16 C units.
  input  wire logic [11:0] sensor_temp,
  // Two-wire serial pins.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Open-drain alarm pin.
  output logic             alarm_out,
  output logic             alarm_oe,
  // Status.
  output logic             standby
);

  // Bus slave state.
  tct_bus_state_t state_reg;
  logic        scl_q_reg;
  logic        sda_q_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [1:0]  wr_cnt_reg;
  logic        rw_reg;
  logic        ridx_reg;
  logic        nack_reg;
  logic [15:0] shadow_reg;
  logic        sda_oe_reg;
  logic        sda_out_reg;

  // Register file.
  logic [1:0]  ptr_reg;
  logic [7:0]  cfg_reg;
  logic [15:0] trip_reg;
  logic [15:0] hyst_reg;
  logic [15:0] temp_reg;

  // Converter and thermostat.
  logic [25:0] conv_cnt_reg;
  logic        busy_reg;
  logic [2:0]  fcnt_reg;
  logic        alarm_reg;
  logic        tgt_low_reg;
  logic        alarm_oe_reg;
  logic        alarm_out_reg;
  logic        standby_reg;
  logic [14:0] alone_cnt_reg;

  // Conversions needed in a row before a fault counts for each code.
  function automatic logic [2:0] fault_need(input logic [1:0] code);
    unique case (code)
      2'b00:   fault_need = 3'h1;
      2'b01:   fault_need = 3'h2;
      2'b10:   fault_need = 3'h4;
      default: fault_need = 3'h6;
    endcase
  endfunction : fault_need

  // Configuration decode.
  wire         cfg_sd  = cfg_reg[CFG_SD];
  wire         cfg_tm  = cfg_reg[CFG_TM];
  wire         cfg_pol = cfg_reg[CFG_POL];
  wire [1:0]   cfg_ft  = cfg_reg[CFG_FT_LSB +: 2];
  wire [1:0]   cfg_res = cfg_reg[CFG_RES_LSB +: 2];

  // Bus edge and framing decode.
  wire scl_rise = scl_in & ~scl_q_reg;
  wire scl_fall = ~scl_in & scl_q_reg;
  wire bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  wire bus_stop  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  wire bit_full  = (bit_cnt_reg == BYTE_BITS);
  wire addr_match = (shift_reg[7:1] == DEV_ADDR);
  wire addr_done = (state_reg == ST_ADDR) & scl_fall & bit_full;
  // Any read address clears an interrupt alarm, whichever register it reads.
  wire rd_event  = addr_done & addr_match & shift_reg[0];
  wire wr_commit = (state_reg == ST_WRITE) & scl_fall & bit_full;
  wire wr_ptr    = wr_commit & (wr_cnt_reg == 2'h0);
  wire wr_hi     = wr_commit & (wr_cnt_reg == 2'h1);
  wire wr_lo     = wr_commit & (wr_cnt_reg == 2'h2);
  // Only a step of the shutdown bit from 0 to 1 counts as entering shutdown.
  wire sd_on     = wr_hi & (ptr_reg == PTR_CFG) & shift_reg[CFG_SD] & ~cfg_sd;
  wire [7:0] rd_byte = ridx_reg ? shadow_reg[7:0] : shadow_reg[15:8];

  // Read data is snapshotted at address time so a finishing conversion
  // cannot tear the two bytes of one transfer.
  wire [15:0] reg_view =
      (ptr_reg == PTR_TEMP) ? temp_reg :
      (ptr_reg == PTR_CFG)  ? {cfg_reg, cfg_reg} :
      (ptr_reg == PTR_HYST) ? hyst_reg : trip_reg;

  // Converter decode.
  wire [25:0] conv_base = 26'(CONV9_CYCLES);
  wire [25:0] conv_len  = conv_base << cfg_res;
  // A resolution lowered mid-conversion can leave the count past the new
  // end, so the end test is a bound, not an equality, to avoid a long stall.
  wire        conv_end  = (conv_cnt_reg >= conv_len - 26'h1);
  wire        conv_done = busy_reg & conv_end;
  // Result bits below the chosen resolution are forced to zero.
  wire [11:0] res_mask  = 12'(12'hFFF << (2'h3 - cfg_res));
  wire [15:0] result    = {sensor_temp & res_mask, 4'h0};

  // Standalone hysteresis select.
  wire [14:0] alone_max  = 15'(ALONE_CYCLES - 1);
  wire        standalone = (alone_cnt_reg == alone_max);
  wire [15:0] hyst_eff   = standalone ?
                           (sda_in ? HYST_RESET : ALONE_HYST_SDA_LO) :
                           hyst_reg;

  // Thermostat decode.
  wire       over_trip = $signed(result) >= $signed(trip_reg);
  wire       under_rel = $signed(result) <  $signed(hyst_eff);
  wire       beyond    = cfg_tm ? (tgt_low_reg ? under_rel : over_trip)
                                : (~alarm_reg & over_trip);
  wire [2:0] fcnt_inc  = fcnt_reg + 3'h1;
  wire       fault_hit = beyond & (fcnt_inc == fault_need(cfg_ft));
  wire       int_clear = cfg_tm & (rd_event | sd_on);

  // The data pin only sinks: a one is sent by letting go of the line.
  wire sda_oe_next = (state_reg == ST_ACK) |
                     ((state_reg == ST_READ) & ~tx_reg[7]);

  // Serial slave.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      scl_q_reg   <= 1'b1;
      sda_q_reg   <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'hFF;
      wr_cnt_reg  <= 2'h0;
      rw_reg      <= 1'b0;
      ridx_reg    <= 1'b0;
      nack_reg    <= 1'b0;
      shadow_reg  <= 16'h0000;
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      scl_q_reg  <= scl_in;
      sda_q_reg  <= sda_in;
      sda_oe_reg <= sda_oe_next;
      if (bus_stop) begin
        state_reg <= ST_IDLE;
      end else if (bus_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        wr_cnt_reg  <= 2'h0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise && !bit_full) begin
              shift_reg   <= {shift_reg[6:0], sda_in};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_full) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_WRITE) begin
                state_reg <= ST_ACK;
                if (wr_cnt_reg != 2'h3) begin
                  wr_cnt_reg <= wr_cnt_reg + 2'h1;
                end
              end else if (addr_match) begin
                state_reg  <= ST_ACK;
                rw_reg     <= shift_reg[0];
                ridx_reg   <= 1'b0;
                shadow_reg <= reg_view;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_reg <= rw_reg ? ST_READ : ST_WRITE;
              tx_reg    <= rd_byte;
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_reg == LAST_BIT) begin
                state_reg   <= ST_RACK;
                bit_cnt_reg <= 4'h0;
                ridx_reg    <= ~ridx_reg;
                tx_reg      <= 8'hFF;
              end else begin
                tx_reg      <= {tx_reg[6:0], 1'b1};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= sda_in;
            end else if (scl_fall) begin
              state_reg <= nack_reg ? ST_IDLE : ST_READ;
              tx_reg    <= rd_byte;
            end
          end
        endcase
      end
    end
  end

  // Host-written registers; setpoints keep 1/16 C steps.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg  <= PTR_RESET;
      cfg_reg  <= CFG_RESET;
      trip_reg <= TRIP_RESET;
      hyst_reg <= HYST_RESET;
    end else begin
      if (wr_ptr) begin
        ptr_reg <= shift_reg[1:0];
      end
      if (wr_hi && ptr_reg == PTR_CFG) begin
        cfg_reg <= shift_reg & CFG_WMASK;
      end
      if (wr_hi && ptr_reg == PTR_TRIP) begin
        trip_reg[15:8] <= shift_reg;
      end
      // Low setpoint bytes keep only their top nibble, the 1/16 C grid.
      if (wr_lo && ptr_reg == PTR_TRIP) begin
        trip_reg[7:0] <= {shift_reg[7:4], 4'h0};
      end
      if (wr_hi && ptr_reg == PTR_HYST) begin
        hyst_reg[15:8] <= shift_reg;
      end
      if (wr_lo && ptr_reg == PTR_HYST) begin
        hyst_reg[7:0] <= {shift_reg[7:4], 4'h0};
      end
    end
  end

  // Converter: a shutdown request only takes effect at a conversion end.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg     <= 1'b1;
      conv_cnt_reg <= 26'h0;
      temp_reg     <= TEMP_RESET;
      standby_reg  <= 1'b0;
    end else begin
      // Standby lags the converter by one cycle so it leaves a flip-flop.
      standby_reg <= ~busy_reg;
      if (busy_reg) begin
        if (conv_end) begin
          conv_cnt_reg <= 26'h0;
          temp_reg     <= result;
          busy_reg     <= ~cfg_sd;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 26'h1;
        end
      end else if (!cfg_sd) begin
        busy_reg <= 1'b1;
      end
    end
  end

  // Standalone detect: the clock pin must sit low for a long stretch so a
  // slow host clock is not mistaken for standalone use.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alone_cnt_reg <= 15'h0;
    end else if (scl_in) begin
      alone_cnt_reg <= 15'h0;
    end else if (!standalone) begin
      alone_cnt_reg <= alone_cnt_reg + 15'h1;
    end
  end

  // Thermostat. A fault set in the same cycle as a clear wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcnt_reg      <= 3'h0;
      alarm_reg     <= 1'b0;
      tgt_low_reg   <= 1'b0;
      alarm_oe_reg  <= 1'b0;
      alarm_out_reg <= 1'b0;
    end else begin
      // The pin only pulls low, so polarity decides when it is pulled.
      alarm_oe_reg <= alarm_reg ^ cfg_pol;
      if (conv_done) begin
        fcnt_reg <= (beyond && !fault_hit) ? fcnt_inc : 3'h0;
      end
      if (!cfg_tm) begin
        tgt_low_reg <= 1'b0;
        if (conv_done && !alarm_reg && fault_hit) begin
          alarm_reg <= 1'b1;
        end else if (conv_done && alarm_reg && under_rel) begin
          alarm_reg <= 1'b0;
        end
      end else if (conv_done && fault_hit) begin
        alarm_reg   <= 1'b1;
        tgt_low_reg <= ~tgt_low_reg;
      end else if (int_clear) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  assign sda_out   = sda_out_reg;
  assign sda_oe    = sda_oe_reg;
  assign alarm_out = alarm_out_reg;
  assign alarm_oe  = alarm_oe_reg;
  assign standby   = standby_reg;

endmodule : tct_core

// File: tct_host.sv
`timescale 1ns/1ps

module tct_host
  import tct_pkg::*;
#(
  parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and resolved data line.
  input  wire logic clk,
  input  wire logic sda_in,
  // Host pins; a released data line is pulled up outside.
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Pins move just after an edge and then hold for n cycles.
  task automatic pins(input logic c, input logic d, input int n);
    scl = c;
    sda_drv = d;
    repeat (n) @(posedge clk);
    #1;
  endtask : pins

  task automatic bus_start;
    pins(1'b0, 1'b1, 1);
    pins(1'b1, 1'b1, 4);
    pins(1'b1, 1'b0, 4);
    pins(1'b0, 1'b0, 1);
  endtask : bus_start

  task automatic bus_stop;
    pins(1'b0, 1'b0, 4);
    pins(1'b1, 1'b0, 4);
    pins(1'b1, 1'b1, 4);
  endtask : bus_stop

  // Eight data bits, then the acknowledge slot in v[0].
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [8:0] v);
    logic b;
    v = {d, a};
    for (int i = 8; i >= 0; i--) begin
      b = v[i];
      pins(1'b0, b, 4);
      pins(1'b1, b, 2);
      v[i] = sda_in;
      pins(1'b1, b, 2);
      pins(1'b0, b, 1);
    end
  endtask : xbyte

  // The pointer byte always comes first; n data bytes follow.
  task automatic wr(input logic [1:0] p, input logic [15:0] d,
                    input int n);
    logic [8:0] v;
    bus_start();
    xbyte({ADDR, 1'b0}, 1'b1, v);
    xbyte({6'h00, p}, 1'b1, v);
    if (n == 2)
      xbyte(d[15:8], 1'b1, v);
    if (n > 0)
      xbyte(d[7:0], 1'b1, v);
    bus_stop();
  endtask : wr

  task automatic rd16(output logic [15:0] d);
    logic [8:0] hi;
    logic [8:0] lo;
    bus_start();
    xbyte({ADDR, 1'b1}, 1'b1, hi);
    xbyte(8'hFF, 1'b0, hi);
    xbyte(8'hFF, 1'b1, lo);
    bus_stop();
    d = {hi[8:1], lo[8:1]};
  endtask : rd16
endmodule : tct_host

// File: tct_asserts.sv
`timescale 1ns/1ps

module tct_asserts
  import tct_pkg::*;
#(
  parameter int CONV9_CYCLES = CONV9_CYC
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Pins of the core.
  input wire logic [11:0] sensor_temp,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        alarm_out,
  input wire logic        alarm_oe,
  input wire logic        standby
);
  int cyc;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Nothing can be finished before one full 9-bit conversion.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cyc <= 0;
    else if (cyc < CONV9_CYCLES)
      cyc <= cyc + 1;
  end

  sequence idle_standby_s;
    (standby && scl_in) [*3];
  endsequence

  sda_drive_zero_a: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  alarm_drive_zero_a: assert property (alarm_out == 1'b0)
    else $error("alarm_out not low");
  sda_low_clock_a: assert property (
    $changed(sda_oe) && !$past(rst) |-> !scl_in && !$past(scl_in))
    else $error("sda moved while scl high");
  sda_bit_hold_a: assert property (
    $rose(scl_in) |=> $stable(sda_oe) [*2])
    else $error("sda bit not held");
  first_conv_a: assert property (
    cyc < CONV9_CYCLES |-> !alarm_oe && !standby)
    else $error("output before first conversion");
  standby_alarm_a: assert property (
    idle_standby_s |-> $stable(alarm_oe))
    else $error("alarm moved in standby");
  standby_hold_a: assert property (
    standby && scl_in && $past(scl_in) |=> standby)
    else $error("standby left without a write");
  resume_conv_a: assert property (
    $fell(standby) |-> !scl_in)
    else $error("standby left outside a write");
endmodule : tct_asserts

bind tct_core tct_asserts #(.CONV9_CYCLES(CONV9_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .sensor_temp(sensor_temp), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .alarm_out(alarm_out), .alarm_oe(alarm_oe), .standby(standby));

// File: tb.sv
`timescale 1ns/1ps

module tb;
  import tct_pkg::*;
  localparam int C = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] sensor_temp = 12'h008;
  wire         scl_w;
  wire         host_sda;
  wire         sda_w;
  logic        sda_oe;
  logic        alarm_oe;
  logic        standby;
  logic [15:0] q;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;
  // The pull-up wins wherever nobody pulls the data line low.
  assign sda_w = host_sda & ~sda_oe;

  tct_core #(.CONV9_CYCLES(C), .ALONE_CYCLES(12)) DUT (
    .clk(clk), .rst(rst), .sensor_temp(sensor_temp), .scl_in(scl_w),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .alarm_out(),
    .alarm_oe(alarm_oe), .standby(standby));
  tct_host HOST (.clk(clk), .sda_in(sda_w), .scl(scl_w), .sda_drv(host_sda));

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask : chk_pin

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic rd_reg(input logic [1:0] p);
    HOST.wr(p, 16'h0000, 0);
    HOST.rd16(q);
  endtask : rd_reg

  task automatic t_reset;
    wait_clk(2 * C);
    HOST.rd16(q);
    chk_reg(q, 16'h0080);
    rd_reg(PTR_TRIP);
    chk_reg(q, 16'h5000);
    rd_reg(PTR_HYST);
    chk_reg(q, 16'h4B00);
  endtask : t_reset

  task automatic t_res;
    logic [15:0] exp;
    sensor_temp = 12'hF5F;
    for (int r = 0; r < 4; r++) begin
      exp = (r == 0) ? 16'hF580 : (r == 1) ? 16'hF5C0 :
            (r == 2) ? 16'hF5E0 : 16'hF5F0;
      HOST.wr(PTR_CFG, {8'h00, 1'b0, r[1:0], 5'h00}, 1);
      wait_clk(17 * C);
      rd_reg(PTR_TEMP);
      chk_reg(q, exp);
    end
  endtask : t_res

  // Counts are timed from the sample change, as conversion ends are hidden.
  task automatic t_fault;
    int n;
    for (int f = 0; f < 4; f++) begin
      HOST.wr(PTR_CFG, {11'h000, f[1:0], 3'h0}, 1);
      wait_clk(10 * C);
      n = (f == 3) ? 6 : (1 << f);
      sensor_temp = 12'h500;
      wait_clk((n - 1) * C);
      chk_pin(alarm_oe, 1'b0);
      wait_clk(C + 3);
      chk_pin(alarm_oe, 1'b1);
      sensor_temp = 12'h4B0;
      wait_clk(2 * C);
      chk_pin(alarm_oe, 1'b1);
      sensor_temp = 12'h4AF;
      wait_clk(C + 3);
      chk_pin(alarm_oe, 1'b0);
    end
  endtask : t_fault

  task automatic t_modes;
    HOST.wr(PTR_CFG, 16'h0002, 1);
    sensor_temp = 12'h500;
    wait_clk(C + 3);
    chk_pin(alarm_oe, 1'b1);
    rd_reg(PTR_CFG);
    chk_pin(alarm_oe, 1'b0);
    wait_clk(2 * C);
    chk_pin(alarm_oe, 1'b0);
    sensor_temp = 12'h400;
    wait_clk(C + 3);
    chk_pin(alarm_oe, 1'b1);
    HOST.wr(PTR_CFG, 16'h0003, 1);
    chk_pin(alarm_oe, 1'b0);
    wait_clk(C + 3);
    chk_pin(standby, 1'b1);
    sensor_temp = 12'h190;
    wait_clk(3 * C);
    rd_reg(PTR_TEMP);
    chk_reg(q, 16'h4000);
    HOST.wr(PTR_CFG, 16'h0004, 1);
    chk_pin(standby, 1'b0);
    chk_pin(alarm_oe, 1'b1);
    wait_clk(2 * C);
    rd_reg(PTR_TEMP);
    chk_reg(q, 16'h1900);
  endtask : t_modes

  // A long low clock pin selects standalone use; low data means 70 C.
  task automatic t_alone;
    HOST.wr(PTR_CFG, 16'h0000, 1);
    HOST.scl = 1'b0;
    wait_clk(1);
    HOST.sda_drv = 1'b0;
    sensor_temp = 12'h500;
    wait_clk(C + 15);
    chk_pin(alarm_oe, 1'b1);
    sensor_temp = 12'h480;
    wait_clk(2 * C + 3);
    chk_pin(alarm_oe, 1'b1);
    sensor_temp = 12'h450;
    wait_clk(C + 3);
    chk_pin(alarm_oe, 1'b0);
    HOST.sda_drv = 1'b1;
    wait_clk(1);
    HOST.scl = 1'b1;
    wait_clk(4);
  endtask : t_alone

  task automatic t_rereset;
    HOST.wr(PTR_TRIP, 16'h2800, 2);
    rd_reg(PTR_TRIP);
    chk_reg(q, 16'h2800);
    rst = 1'b1;
    wait_clk(2);
    rst = 1'b0;
    wait_clk(2 * C);
    HOST.rd16(q);
    chk_reg(q, 16'h4500);
    rd_reg(PTR_TRIP);
    chk_reg(q, 16'h5000);
  endtask : t_rereset

  initial begin
    wait_clk(3);
    rst = 1'b0;
    wait_clk(2);
    t_reset();
    t_res();
    t_fault();
    t_modes();
    t_alone();
    t_rereset();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : tb
